// ### verilog/ldo_regulator_control_regs.sv
/*
 * Control register bank for two linear regulators, APB slave, with
 * one-time-memory preload, standby pin decode and per-regulator outputs.
 * Assumes preload values are stable from reset release onward and the
 * standby pin is asynchronous; the sleep state comes from same-clock logic.
 */
// Added by the designer: the APB interface to the registers.
// Overview of operation
// - Regulator A keeps a five-bit voltage code at bits 4:0, preloaded from one-time memory and host writable.
// - Regulator B keeps a four-bit voltage code at bits 3:0, preloaded from one-time memory and host writable.
// - Control bit 0 is the run enable, preloaded by power-up; 1 turns the regulator on and clearing it turns it off.
// - Control bit 1 keeps the regulator on in Standby when 1 and off when 0, resetting to 0.
// - Control bit 2 is a plain read-write bit, reset 0, enabling the regulator in Sleep.
// - Control bit 3, reset 0, puts the regulator in low-power mode during Standby and Sleep.
// - Regulator A's switch-mode bit 4 is preloaded and may go 0 to 1 by the host, never back to 0.
// - With the switch-mode bit set the output is driven fully on, otherwise it regulates.
// - Standby is entered from the standby pin whose active level a polarity bit picks: 0 high, 1 low.
module ldo_regulator_control_regs
	import ldo_regs_pkg::*;
(
	input  wire logic                clock_i,
	input  wire logic                rst_i,
	// APB
	input  wire logic                psel_i,
	input  wire logic                penable_i,
	input  wire logic                pwrite_i,
	input  wire logic [31:0]         paddr_i,
	input  wire logic [31:0]         pwdata_i,
	input  wire logic [3:0]          pstrb_i,
	output logic                     pready_o,
	output logic [31:0]              prdata_o,
	output logic                     pslverr_o,
	// Preload from one-time memory
	input  wire logic [A_CODE_W-1:0] preset_a_code_i,
	input  wire logic [B_CODE_W-1:0] preset_b_code_i,
	input  wire logic                preset_a_run_i,
	input  wire logic                preset_b_run_i,
	input  wire logic                preset_switch_mode_i,
	// Power state
	input  wire logic                standby_pin_i,
	input  wire logic                sleep_req_i,
	// Regulator controls
	output logic [A_CODE_W-1:0]      reg_a_code_o,
	output logic [B_CODE_W-1:0]      reg_b_code_o,
	output logic                     reg_a_on_o,
	output logic                     reg_b_on_o,
	output logic                     reg_a_low_power_o,
	output logic                     reg_b_low_power_o,
	output logic                     reg_a_switch_o,
	output logic                     standby_o,
	output logic                     sleep_o
);

	////////////////////////////////////////////////////////////////////////
	// Registers

	logic [A_CODE_W-1:0] reg_a_voltage_code_q;
	logic [B_CODE_W-1:0] reg_b_voltage_code_q;
	logic [1:0]          run_enable_q;
	logic [1:0]          standby_enable_q;
	logic [1:0]          sleep_enable_q;
	logic [1:0]          low_power_select_q;
	logic                reg_a_switch_mode_q;
	logic                standby_pin_polarity_q;
	logic                preload_pend_q;
	logic                standby_sync;
	logic                standby_active;
	power_state_t        state_q;
	power_state_t        state_d;

	////////////////////////////////////////////////////////////////////////
	// APB decode

	logic [IDX_W-1:0] idx;
	logic             in_range;
	logic             wr;
	logic             rd_hit;
	logic             wr_lo;

	assign idx      = paddr_i[ADDR_LSB +: IDX_W];
	// Upper address bits must be zero to alias nothing
	assign in_range = (paddr_i[31:ADDR_LSB+IDX_W] == '0) && (paddr_i[ADDR_LSB-1:0] == 2'h0);
	assign pready_o = 1'b1;
	assign wr_lo    = pstrb_i[0];
	always_comb begin
		rd_hit = 1'b0;
		if (in_range) begin
			unique case (idx)
				IDX_REG_A_VOLTAGE_CODE,
				IDX_REG_A_CONTROL,
				IDX_REG_B_VOLTAGE_CODE,
				IDX_REG_B_CONTROL,
				IDX_STANDBY_CONFIG,
				IDX_STATUS: rd_hit = 1'b1;
				default:    rd_hit = 1'b0;
			endcase
		end
	end
	// Status is read-only: writes there are dropped, not flagged
	assign wr = psel_i && penable_i && pwrite_i && wr_lo && rd_hit && (idx != IDX_STATUS);

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			pslverr_o <= 1'b0;
		end else begin
			pslverr_o <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Preload: one cycle after reset release, so no port feeds the reset branch

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			preload_pend_q <= PRELOAD_PEND_RST;
		end else begin
			preload_pend_q <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			reg_a_voltage_code_q <= A_CODE_RST;
		end else if (preload_pend_q) begin
			reg_a_voltage_code_q <= preset_a_code_i;
		end else if (wr && idx == IDX_REG_A_VOLTAGE_CODE) begin
			reg_a_voltage_code_q <= pwdata_i[A_CODE_W-1:0];
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			reg_b_voltage_code_q <= B_CODE_RST;
		end else if (preload_pend_q) begin
			reg_b_voltage_code_q <= preset_b_code_i;
		end else if (wr && idx == IDX_REG_B_VOLTAGE_CODE) begin
			reg_b_voltage_code_q <= pwdata_i[B_CODE_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control bits, one generate entry per regulator

	logic [1:0] preset_run;
	assign preset_run = {preset_b_run_i, preset_a_run_i};

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ctrl
			logic hit;
			assign hit = wr && (idx == ((g == 0) ? IDX_REG_A_CONTROL : IDX_REG_B_CONTROL));
			always_ff @(posedge clock_i or posedge rst_i) begin
				if (rst_i) begin
					run_enable_q[g]       <= CTRL_BIT_RST;
					standby_enable_q[g]   <= CTRL_BIT_RST;
					sleep_enable_q[g]     <= CTRL_BIT_RST;
					low_power_select_q[g] <= CTRL_BIT_RST;
				end else if (preload_pend_q) begin
					run_enable_q[g] <= preset_run[g];
				end else if (hit) begin
					run_enable_q[g]       <= pwdata_i[CTRL_RUN_BIT];
					standby_enable_q[g]   <= pwdata_i[CTRL_STBY_BIT];
					sleep_enable_q[g]     <= pwdata_i[CTRL_SLEEP_BIT];
					low_power_select_q[g] <= pwdata_i[CTRL_LPWR_BIT];
				end
			end
		end
	endgenerate

	// Set-only: once on, only a reset can leave switch mode
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			reg_a_switch_mode_q <= CTRL_BIT_RST;
		end else if (preload_pend_q) begin
			reg_a_switch_mode_q <= preset_switch_mode_i;
		end else if (wr && idx == IDX_REG_A_CONTROL && pwdata_i[CTRL_SWITCH_BIT]) begin
			reg_a_switch_mode_q <= 1'b1;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			standby_pin_polarity_q <= POLARITY_RST;
		end else if (wr && idx == IDX_STANDBY_CONFIG) begin
			standby_pin_polarity_q <= pwdata_i[POLARITY_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Power state

	pin_sync u_standby_sync (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.async_i (standby_pin_i),
		.sync_o  (standby_sync)
	);

	assign standby_active = standby_sync ^ standby_pin_polarity_q;

	// Standby takes priority over sleep
	always_comb begin
		if (standby_active) begin
			state_d = PWR_STANDBY;
		end else if (sleep_req_i) begin
			state_d = PWR_SLEEP;
		end else begin
			state_d = PWR_RUN;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= PWR_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Regulator outputs

	logic [1:0] on_d;
	logic [1:0] lp_d;

	always_comb begin
		on_d = '0;
		lp_d = '0;
		unique case (state_q)
			PWR_RUN: begin
				on_d = run_enable_q;
			end
			PWR_STANDBY: begin
				on_d = run_enable_q & standby_enable_q;
				lp_d = low_power_select_q;
			end
			PWR_SLEEP: begin
				on_d = run_enable_q & sleep_enable_q;
				lp_d = low_power_select_q;
			end
			default: begin
				on_d = '0;
			end
		endcase
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			reg_a_on_o        <= 1'b0;
			reg_b_on_o        <= 1'b0;
			reg_a_low_power_o <= 1'b0;
			reg_b_low_power_o <= 1'b0;
			reg_a_switch_o    <= 1'b0;
			reg_a_code_o      <= A_CODE_RST;
			reg_b_code_o      <= B_CODE_RST;
			standby_o         <= 1'b0;
			sleep_o           <= 1'b0;
		end else begin
			reg_a_on_o        <= on_d[0];
			reg_b_on_o        <= on_d[1];
			reg_a_low_power_o <= lp_d[0] & on_d[0];
			reg_b_low_power_o <= lp_d[1] & on_d[1];
			reg_a_switch_o    <= reg_a_switch_mode_q & on_d[0];
			reg_a_code_o      <= reg_a_voltage_code_q;
			reg_b_code_o      <= reg_b_voltage_code_q;
			standby_o         <= (state_q == PWR_STANDBY);
			sleep_o           <= (state_q == PWR_SLEEP);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data, registered in the setup phase; unused bits zero

	logic [31:0] rdata_d;

	always_comb begin
		rdata_d = '0;
		unique case (idx)
			IDX_REG_A_VOLTAGE_CODE: rdata_d[A_CODE_W-1:0] = reg_a_voltage_code_q;
			IDX_REG_B_VOLTAGE_CODE: rdata_d[B_CODE_W-1:0] = reg_b_voltage_code_q;
			IDX_REG_A_CONTROL: begin
				rdata_d[CTRL_RUN_BIT]    = run_enable_q[0];
				rdata_d[CTRL_STBY_BIT]   = standby_enable_q[0];
				rdata_d[CTRL_SLEEP_BIT]  = sleep_enable_q[0];
				rdata_d[CTRL_LPWR_BIT]   = low_power_select_q[0];
				rdata_d[CTRL_SWITCH_BIT] = reg_a_switch_mode_q;
			end
			IDX_REG_B_CONTROL: begin
				rdata_d[CTRL_RUN_BIT]   = run_enable_q[1];
				rdata_d[CTRL_STBY_BIT]  = standby_enable_q[1];
				rdata_d[CTRL_SLEEP_BIT] = sleep_enable_q[1];
				rdata_d[CTRL_LPWR_BIT]  = low_power_select_q[1];
			end
			IDX_STANDBY_CONFIG: rdata_d[POLARITY_BIT] = standby_pin_polarity_q;
			IDX_STATUS: begin
				rdata_d[0] = reg_a_on_o;
				rdata_d[1] = reg_b_on_o;
				rdata_d[2] = standby_o;
				rdata_d[3] = sleep_o;
			end
			default: rdata_d = '0;
		endcase
		if (!in_range) begin
			rdata_d = '0;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			prdata_o <= '0;
		end else if (psel_i && !penable_i && !pwrite_i) begin
			prdata_o <= rdata_d;
		end
	end

endmodule : ldo_regulator_control_regs

// ### verilog/ldo_regs_pkg.sv
/*
 * Package for the two-regulator control register bank: register indices,
 * field positions, reset values and state encodings.
 * Assumes a 32-bit APB with one aligned word per register.
 */
package ldo_regs_pkg;

	// Printed offsets are not all multiples of four: they are indices, byte address = 4 * index
	localparam logic [7:0] IDX_REG_A_VOLTAGE_CODE = 8'h4c;
	localparam logic [7:0] IDX_REG_A_CONTROL      = 8'h4d;
	localparam logic [7:0] IDX_REG_B_VOLTAGE_CODE = 8'h4f;
	localparam logic [7:0] IDX_REG_B_CONTROL      = 8'h50;
	// Own register: standby pin polarity
	localparam logic [7:0] IDX_STANDBY_CONFIG     = 8'h58;
	// Own register: read-only live status
	localparam logic [7:0] IDX_STATUS             = 8'h5a;

	localparam int ADDR_LSB = 2;
	localparam int IDX_W    = 8;

	// Field positions
	localparam int A_CODE_W        = 5;
	localparam int B_CODE_W        = 4;
	localparam int CTRL_RUN_BIT    = 0;
	localparam int CTRL_STBY_BIT   = 1;
	localparam int CTRL_SLEEP_BIT  = 2;
	localparam int CTRL_LPWR_BIT   = 3;
	localparam int CTRL_SWITCH_BIT = 4;
	localparam int POLARITY_BIT    = 2;

	// Reset values
	localparam logic [4:0] A_CODE_RST    = 5'h00;
	localparam logic [3:0] B_CODE_RST    = 4'h0;
	localparam logic       CTRL_BIT_RST  = 1'b0;
	localparam logic       POLARITY_RST  = 1'b0;
	// Preload source taken one cycle after reset release
	localparam logic       PRELOAD_PEND_RST = 1'b1;

	typedef enum logic [2:0] {
		PWR_RUN     = 3'b001,
		PWR_STANDBY = 3'b010,
		PWR_SLEEP   = 3'b100
	} power_state_t;

endpackage : ldo_regs_pkg

// ### verilog/pin_sync.sv
/*
 * Two-flip-flop synchroniser for one asynchronous level.
 * Assumes the input changes slowly relative to clock_i.
 */
module pin_sync (
	input  wire logic clock_i,
	input  wire logic rst_i,
	input  wire logic async_i,
	output logic      sync_o
);

	logic meta_q;

	// First stage is read only by the second
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			meta_q <= 1'b0;
			sync_o <= 1'b0;
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end

endmodule : pin_sync

// ### test/apb_host.sv
/* Host model: APB master, one transfer at a time.
   Assumes it shares clock_i with the slave. */
module apb_host (
	input  wire logic        clock_i,
	input  wire logic        pready_i,
	input  wire logic [31:0] prdata_i,
	output logic             psel_o,
	output logic             penable_o,
	output logic             pwrite_o,
	output logic [31:0]      paddr_o,
	output logic [31:0]      pwdata_o,
	output logic [3:0]       pstrb_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int timeouts = 0;
	// Strobe for the next transfer; the bench lowers bit 0 to try a refused write
	logic [3:0] strb = 4'hf;
	initial begin
		{psel_o, penable_o, pwrite_o, pstrb_o} = 7'h00;
		paddr_o = 32'h0;
		pwdata_o = 32'h0;
	end
	task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
		int n;
		@(posedge clock_i);
		psel_o <= 1'b1;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		pstrb_o <= strb;
		@(posedge clock_i);
		penable_o <= 1'b1;
		n = 0;
		do begin
			@(posedge clock_i);
			n++;
		end while (pready_i !== 1'b1 && n < 64);
		if (pready_i !== 1'b1) begin
			timeouts++;
			tb_top.complete_run();
		end
		r = prdata_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		// Released lines flip, so a stale value never passes
		paddr_o <= ~a;
		pwdata_o <= ~d;
	endtask : xfer
endmodule : apb_host

// ### test/ldo_regs_chk.sv
/* Checker: write effects, read padding, switch and low-power outputs.
   Bound to the register bank; sees its ports only. */
module ldo_regs_chk (
	input wire logic        clock_i,
	input wire logic        rst_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [31:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0]  pstrb_i,
	input wire logic [31:0] prdata_o,
	input wire logic [4:0]  reg_a_code_o,
	input wire logic [3:0]  reg_b_code_o,
	input wire logic        reg_a_on_o,
	input wire logic        reg_b_on_o,
	input wire logic        reg_a_low_power_o,
	input wire logic        reg_a_switch_o,
	input wire logic        standby_o,
	input wire logic        sleep_o
);
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (rst_i);
	sequence s_wr(logic [31:0] a);
		psel_i && penable_i && pwrite_i && pstrb_i[0] && paddr_i == a;
	endsequence
	sequence s_rd(logic [31:0] a);
		psel_i && !penable_i && !pwrite_i && paddr_i == a;
	endsequence
	////////////////////////////////////////
	// Outputs copy the register one edge late, hence two cycles
	property p_a_code; s_wr(32'h130) |-> ##2 reg_a_code_o == 5'($past(pwdata_i, 2)); endproperty
	property p_b_code; s_wr(32'h13c) |-> ##2 reg_b_code_o == 4'($past(pwdata_i, 2)); endproperty
	property p_a_off; s_wr(32'h134) ##0 !pwdata_i[0] |-> ##2 !reg_a_on_o; endproperty
	property p_b_off; s_wr(32'h140) ##0 !pwdata_i[0] |-> ##2 !reg_b_on_o; endproperty
	property p_sw_hold; $fell(reg_a_switch_o) |-> !reg_a_on_o; endproperty
	property p_sw_set; s_wr(32'h134) ##0 pwdata_i[4] |-> ##2 reg_a_switch_o == reg_a_on_o; endproperty
	property p_lp; reg_a_low_power_o |-> standby_o || sleep_o || $past(standby_o || sleep_o); endproperty
	property p_rd_pad; s_rd(32'h13c) |=> prdata_o[31:4] == 28'h0; endproperty
	a_a_code:
		assert property (p_a_code) else $error("a code output wrong");
	a_b_code:
		assert property (p_b_code) else $error("b code output wrong");
	a_a_off:
		assert property (p_a_off) else $error("a stays on");
	a_b_off:
		assert property (p_b_off) else $error("b stays on");
	a_sw_hold:
		assert property (p_sw_hold) else $error("switch cleared");
	a_sw_set:
		assert property (p_sw_set) else $error("switch not set");
	a_lp:
		assert property (p_lp) else $error("low power in run");
	a_rd_pad:
		assert property (p_rd_pad) else $error("unused bits set");
endmodule : ldo_regs_chk
bind ldo_regulator_control_regs ldo_regs_chk u_chk (.clock_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
	.pwdata_i, .pstrb_i, .prdata_o, .reg_a_code_o, .reg_b_code_o, .reg_a_on_o, .reg_b_on_o, .reg_a_low_power_o,
	.reg_a_switch_o, .standby_o, .sleep_o);

// ### test/tb_top.sv
/* Testbench: register bank through the host model, seed 93 data,
   power-state table. Assumes zero-wait APB at 20 MHz. */
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, st;
	logic [31:0] paddr_i, pwdata_i, prdata_o, ea, eb, e, d, r, ca;
	logic [3:0]  pstrb_i, preset_b_code_i, reg_b_code_o;
	logic [4:0]  preset_a_code_i, reg_a_code_o;
	logic        preset_a_run_i, preset_b_run_i, preset_switch_mode_i, standby_pin_i, sleep_req_i;
	logic        reg_a_on_o, reg_b_on_o, reg_a_low_power_o, reg_b_low_power_o, reg_a_switch_o, standby_o, sleep_o;
	int          fail_count = 0, checks_done = 0, k;
	logic [31:0] ad [4] = '{32'h130, 32'h134, 32'h13c, 32'h140};
	logic [31:0] mk [4] = '{32'h1f, 32'h1f, 32'h0f, 32'h0f};
	ldo_regulator_control_regs DUT (.clock_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
		.pstrb_i, .pready_o, .prdata_o, .pslverr_o, .preset_a_code_i, .preset_b_code_i, .preset_a_run_i,
		.preset_b_run_i, .preset_switch_mode_i, .standby_pin_i, .sleep_req_i, .reg_a_code_o, .reg_b_code_o,
		.reg_a_on_o, .reg_b_on_o, .reg_a_low_power_o, .reg_b_low_power_o, .reg_a_switch_o, .standby_o, .sleep_o);
	apb_host host (.clock_i, .pready_i(pready_o), .prdata_i(prdata_o), .psel_o(psel_i), .penable_o(penable_i),
		.pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i), .pstrb_o(pstrb_i));
	////////////////////////////////////////
	function automatic logic on_exp(logic [31:0] c, logic s, logic z);
		return s ? c[0] & c[1] : z ? c[0] & c[2] : c[0];
	endfunction : on_exp
	function automatic logic [31:0] rd_exp(int k, logic [31:0] d, a);
		return (d & mk[k]) | (k == 1 ? a & 32'h10 : 32'h0);
	endfunction : rd_exp
	task automatic check(input string nm, input logic [31:0] got, x);
		checks_done++;
		if (got !== x) begin
			fail_count++;
			$display("MISMATCH %s exp %h got %h", nm, x, got);
		end
	endtask : check
	task automatic rchk(input logic [31:0] a, x);
		host.xfer(1'b0, a, 32'h0, r);
		check("prdata", r, x);
	endtask : rchk
	task automatic complete_run;
		fail_count += host.timeouts;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run
	initial begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end
	initial begin
		void'($urandom(93));
		rst_i = 1'b1;
		{preset_a_code_i, preset_b_code_i, preset_a_run_i, preset_b_run_i, preset_switch_mode_i} = 12'($urandom);
		standby_pin_i = 1'b0;
		sleep_req_i = 1'b0;
		repeat (10) @(posedge clock_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		ea = {27'h0, preset_switch_mode_i, 3'h0, preset_a_run_i};
		eb = {31'h0, preset_b_run_i};
		rchk(32'h130, 32'(preset_a_code_i));
		rchk(32'h13c, 32'(preset_b_code_i));
		rchk(32'h134, ea);
		rchk(32'h140, eb);
		check("a_on", reg_a_on_o, preset_a_run_i);
		check("a_sw", reg_a_switch_o, preset_switch_mode_i & preset_a_run_i);
		// First pass writes zeros: a set switch must survive it
		for (int i = 0; i < 40; i++) begin
			k = i % 4;
			d = (i < 4) ? 32'h0 : $urandom;
			host.xfer(1'b1, ad[k], d, r);
			e = rd_exp(k, d, ea);
			if (k == 1)
				ea = e;
			if (k == 0)
				ca = e;
			rchk(ad[k], e);
		end
		host.xfer(1'b1, 32'h144, 32'hff, r);
		rchk(32'h144, 32'h0);
		check("pslverr", pslverr_o, 32'h0);
		// Low byte strobe off, then an alias above the index field: neither may land
		host.strb = 4'he;
		host.xfer(1'b1, 32'h130, ~ca, r);
		host.strb = 4'hf;
		host.xfer(1'b1, 32'h1130, ~ca, r);
		rchk(32'h1130, 32'h0);
		rchk(32'h130, ca);
		host.xfer(1'b1, 32'h134, 32'h1b, r);
		ea = 32'h1b;
		host.xfer(1'b1, 32'h140, 32'h0d, r);
		eb = 32'h0d;
		for (int s = 0; s < 4; s++) begin
			host.xfer(1'b1, 32'h160, (s == 3) ? 32'h4 : 32'h0, r);
			standby_pin_i <= (s == 1);
			sleep_req_i <= (s == 2);
			repeat (5) @(posedge clock_i);
			st = (s == 1 || s == 3);
			check("standby", standby_o, st);
			check("sleep", sleep_o, s == 2);
			check("a_on", reg_a_on_o, on_exp(ea, st, s == 2));
			check("b_on", reg_b_on_o, on_exp(eb, st, s == 2));
			check("a_lp", reg_a_low_power_o, on_exp(ea, st, s == 2) & ea[3] & (st | s == 2));
			check("b_lp", reg_b_low_power_o, on_exp(eb, st, s == 2) & eb[3] & (st | s == 2));
			check("a_sw", reg_a_switch_o, on_exp(ea, st, s == 2) & ea[4]);
			rchk(32'h168, {28'h0, s == 2, st, on_exp(eb, st, s == 2), on_exp(ea, st, s == 2)});
		end
		complete_run();
	end
endmodule : tb_top
